/* design/tmr_pkg.sv */
// shared constants and types of the 16-bit timer control block
package tmr_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CLOCK_EN = 6'h00;
    localparam logic [5:0] IDX_WAVE     = 6'h01;
    localparam logic [5:0] IDX_FORCED   = 6'h02;
    localparam logic [5:0] IDX_SPLIT    = 6'h03;
    localparam logic [5:0] IDX_E_CLR    = 6'h04;
    localparam logic [5:0] IDX_E_SET    = 6'h05;
    localparam logic [5:0] IDX_PERIOD   = 6'h08;
    localparam logic [5:0] IDX_CMP_BUF0 = 6'h09;
    localparam logic [5:0] IDX_COUNT    = 6'h0c;
    localparam logic [5:0] IDX_STATUS   = 6'h0d;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int EN_BIT    = 0;
    localparam int PSEL_LSB  = 1;
    localparam int MODE_LSB  = 0;
    localparam int ALOCK_BIT = 3;
    localparam int CEN_LSB   = 4;
    localparam int DIR_BIT   = 0;
    localparam int HOLD_BIT  = 1;
    localparam int CMD_LSB   = 2;
    localparam int SPLIT_BIT = 0;
    localparam int BV_LSB    = 1;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [15:0] CMP_RST    = 16'h0000;

    // ------------------------------------------------------------------
    // modes and commands
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        WG_NORMAL     = 3'b000,
        WG_FREQ       = 3'b001,
        WG_ONE_SLOPE  = 3'b011,
        WG_TWO_TOP    = 3'b101,
        WG_TWO_BOTH   = 3'b110,
        WG_TWO_BOTTOM = 3'b111
    } tmr_wave_type;

    typedef enum logic [1:0] {
        CMD_NONE       = 2'b00,
        CMD_UPDATE     = 2'b01,
        CMD_RESTART    = 2'b10,
        CMD_HARD_RESET = 2'b11
    } tmr_cmd_type;

    // prescaler mask: a tick whenever the masked count is all ones
    function automatic logic [9:0] tmr_div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    tmr_div_mask = 10'h000;
            3'h1:    tmr_div_mask = 10'h001;
            3'h2:    tmr_div_mask = 10'h003;
            3'h3:    tmr_div_mask = 10'h007;
            3'h4:    tmr_div_mask = 10'h00f;
            3'h5:    tmr_div_mask = 10'h03f;
            3'h6:    tmr_div_mask = 10'h0ff;
            default: tmr_div_mask = 10'h3ff;
        endcase
    endfunction

endpackage

/* design/tmr_prescaler.sv */
// clock prescaler producing the counting tick of the timer
`timescale 1ns/1ns
module tmr_prescaler (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       run_i,
    input  wire logic       clear_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [9:0] count;
    } tmr_psc_type;

    tmr_psc_type s_q;
    tmr_psc_type s_d;
    logic [9:0]  mask;

    assign mask   = tmr_pkg::tmr_div_mask(sel_i);
    assign tick_o = run_i & ((s_q.count & mask) == mask);

    always_comb begin
        s_d = s_q;
        // stopped or restarted prescaler starts a fresh division period
        if (!run_i || clear_i) begin
            s_d.count = 10'h000;
        end else begin
            s_d.count = s_q.count + 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end
endmodule

/* design/tmr_timer16.sv */
// 16-bit timer control registers, counter and waveform outputs
//
// Overview of operation
// - clock select code 0..7 divides clock by 1,2,4,8,16,64,256,1024
// - the timer counts only while its enable bit is one
// - in frequency and pwm modes an enabled channel drives its pin
// - with auto-lock, hold bit stays one until enabled buffers are valid
// - hold bit then stays clear until the next update sets it again
// - without auto-lock only software changes the hold bit
// - mode field picks top, update and overflow; normal and freq at top
// - pwm modes use period as top, update at bottom, overflow per mode
// - normal mode makes no waveform; others reach pins only when enabled
// - while disabled, forced value bits read and write output levels
// - forced value needs pin enable; logic block output bypasses it
// - split bit stops the 16-bit counter and drives split_enable_o
// - writing one to the clear register clears that control bit
// - writing one to the set register sets that control bit
// - command field acts once when written and always reads zero
// - command 1 forces update, 2 forces restart, 0 does nothing
// - command 3 hard-resets the timer, ignored while it is enabled
// - hold bit one blocks updates; zero lets updates happen at the update point
// - the hold bit never blocks an update forced by command
// - direction bit zero counts up, one counts down
// - buffer valid sets on buffer write, clears on update
`timescale 1ns/1ns
module tmr_timer16 (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [2:0]       waveform_out_o,
    output logic [2:0]       waveform_oe_o,
    output logic [2:0]       clb_out_o,
    output logic             overflow_event_o,
    output logic             update_event_o,
    output logic             split_enable_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             enable;
        logic [2:0]       psel;
        logic [2:0]       cmp_en;
        logic             auto_lock;
        logic [2:0]       mode;
        logic [2:0]       wo;
        logic             split;
        logic             hold;
        logic             dir;
        logic [15:0]      period;
        logic [2:0][15:0] cmp_buf;
        logic [2:0][15:0] cmp_val;
        logic [2:0]       bv;
        logic [15:0]      count;
        logic             ovf;
        logic             upd;
        logic [31:0]      rdata;
    } tmr_state_type;

    localparam tmr_state_type STATE_RST = '{
        period:  tmr_pkg::PERIOD_RST,
        cmp_buf: {3{tmr_pkg::CMP_RST}},
        cmp_val: {3{tmr_pkg::CMP_RST}},
        default: '0
    };

    tmr_state_type s_q;
    tmr_state_type s_d;

    logic        req;
    logic        wr;
    logic [5:0]  idx;
    logic        tick;
    logic        run;
    logic        restart;
    logic [7:0]  wdat;
    logic        e_write;
    logic [1:0]  cmd_w;

    assign wdat    = wb_dat_i[7:0];
    assign e_write = wr & ((idx == tmr_pkg::IDX_E_CLR) |
                           (idx == tmr_pkg::IDX_E_SET));
    assign cmd_w   = e_write ? wdat[tmr_pkg::CMD_LSB +: 2] : 2'b00;
    assign restart = (cmd_w == tmr_pkg::CMD_RESTART);
    assign run     = s_q.enable & ~s_q.split;

    // ------------------------------------------------------------------
    // bus handshake and prescaler
    // ------------------------------------------------------------------
    tmr_wb_slave u_bus (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .we_i  (wb_we_i),
        .adr_i (wb_adr_i),
        .sel_i (wb_sel_i),
        .ack_o (wb_ack_o),
        .req_o (req),
        .wr_o  (wr),
        .idx_o (idx)
    );

    tmr_prescaler u_psc (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .run_i   (run),
        .clear_i (restart),
        .sel_i   (s_q.psel),
        .tick_o  (tick)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] top;
        logic        hit_top;
        logic        hit_bot;
        logic        dual;
        logic        pwm;
        logic        upd_hw;
        logic        all_valid;
        logic        do_update;
        top       = 16'h0000;
        hit_top   = 1'b0;
        hit_bot   = 1'b0;
        dual      = 1'b0;
        pwm       = 1'b0;
        upd_hw    = 1'b0;
        all_valid = 1'b0;
        do_update = 1'b0;

        s_d     = s_q;
        s_d.ovf = 1'b0;
        s_d.upd = 1'b0;

        // register writes
        if (wr) begin
            case (idx)
                tmr_pkg::IDX_CLOCK_EN: begin
                    s_d.enable = wdat[tmr_pkg::EN_BIT];
                    s_d.psel   = wdat[tmr_pkg::PSEL_LSB +: 3];
                end
                tmr_pkg::IDX_WAVE: begin
                    s_d.cmp_en    = wdat[tmr_pkg::CEN_LSB +: 3];
                    s_d.auto_lock = wdat[tmr_pkg::ALOCK_BIT];
                    s_d.mode      = wdat[tmr_pkg::MODE_LSB +: 3];
                end
                tmr_pkg::IDX_FORCED: begin
                    // only a stopped timer lets software own the levels
                    if (!s_q.enable) begin
                        s_d.wo = wdat[2:0];
                    end
                end
                tmr_pkg::IDX_SPLIT: begin
                    s_d.split = wdat[tmr_pkg::SPLIT_BIT];
                end
                tmr_pkg::IDX_E_CLR: begin
                    if (wdat[tmr_pkg::HOLD_BIT]) begin
                        s_d.hold = 1'b0;
                    end
                    if (wdat[tmr_pkg::DIR_BIT]) begin
                        s_d.dir = 1'b0;
                    end
                end
                tmr_pkg::IDX_E_SET: begin
                    if (wdat[tmr_pkg::HOLD_BIT]) begin
                        s_d.hold = 1'b1;
                    end
                    if (wdat[tmr_pkg::DIR_BIT]) begin
                        s_d.dir = 1'b1;
                    end
                end
                tmr_pkg::IDX_PERIOD: begin
                    s_d.period = wb_dat_i[15:0];
                end
                default: begin
                end
            endcase
            for (int n = 0; n < 3; n++) begin
                if (idx == tmr_pkg::IDX_CMP_BUF0 + 6'(n)) begin
                    s_d.cmp_buf[n] = wb_dat_i[15:0];
                end
            end
        end

        // counter sequence
        dual = (s_q.mode == tmr_pkg::WG_TWO_TOP) |
               (s_q.mode == tmr_pkg::WG_TWO_BOTH) |
               (s_q.mode == tmr_pkg::WG_TWO_BOTTOM);
        pwm  = dual | (s_q.mode == tmr_pkg::WG_ONE_SLOPE);
        top  = (s_q.mode == tmr_pkg::WG_FREQ) ? s_q.cmp_val[0]
                                              : s_q.period;
        if (tick) begin
            if (!s_q.dir) begin
                if (s_q.count >= top) begin
                    hit_top = 1'b1;
                    if (dual) begin
                        s_d.dir   = 1'b1;
                        s_d.count = s_q.count - 16'h0001;
                    end else begin
                        hit_bot   = 1'b1;
                        s_d.count = 16'h0000;
                    end
                end else begin
                    s_d.count = s_q.count + 16'h0001;
                end
            end else begin
                if (s_q.count == 16'h0000) begin
                    hit_bot = 1'b1;
                    if (dual) begin
                        s_d.dir   = 1'b0;
                        s_d.count = 16'h0001;
                    end else begin
                        s_d.count = top;
                    end
                end else begin
                    s_d.count = s_q.count - 16'h0001;
                end
            end
        end

        // update and overflow points
        upd_hw = pwm ? hit_bot : (hit_top & ~s_q.dir);
        case (s_q.mode)
            tmr_pkg::WG_NORMAL,
            tmr_pkg::WG_FREQ:       s_d.ovf = hit_top & ~s_q.dir;
            tmr_pkg::WG_ONE_SLOPE:  s_d.ovf = hit_bot;
            tmr_pkg::WG_TWO_TOP:    s_d.ovf = hit_top;
            tmr_pkg::WG_TWO_BOTH:   s_d.ovf = hit_top | hit_bot;
            tmr_pkg::WG_TWO_BOTTOM: s_d.ovf = hit_bot;
            default:                s_d.ovf = 1'b0;
        endcase

        do_update = (upd_hw & ~s_q.hold) |
                    (cmd_w == tmr_pkg::CMD_UPDATE);
        if (do_update) begin
            s_d.cmp_val = s_q.cmp_buf;
            s_d.bv      = 3'b000;
            s_d.upd     = 1'b1;
        end
        // a buffer write in the update cycle keeps its valid flag
        for (int n = 0; n < 3; n++) begin
            if (wr && idx == tmr_pkg::IDX_CMP_BUF0 + 6'(n)) begin
                s_d.bv[n] = 1'b1;
            end
        end

        // auto-lock overrides software on the hold bit; off, it never acts
        all_valid = &(s_q.bv | ~s_q.cmp_en);
        if (s_q.auto_lock) begin
            if (upd_hw || !all_valid) begin
                s_d.hold = 1'b1;
            end else begin
                s_d.hold = 1'b0;
            end
        end

        // waveform generator; normal mode leaves the levels alone
        if (tick && s_q.mode == tmr_pkg::WG_FREQ) begin
            for (int n = 0; n < 3; n++) begin
                if (s_q.count == s_q.cmp_val[n]) begin
                    s_d.wo[n] = ~s_q.wo[n];
                end
            end
        end else if (tick && pwm) begin
            for (int n = 0; n < 3; n++) begin
                s_d.wo[n] = s_d.count < s_q.cmp_val[n];
            end
        end

        // restart and hard reset commands
        if (restart) begin
            s_d.count = 16'h0000;
            s_d.dir   = 1'b0;
        end
        if (cmd_w == tmr_pkg::CMD_HARD_RESET && !s_q.enable) begin
            s_d = STATE_RST;
        end

        // read data is captured in the first cycle of a request
        if (req) begin
            case (idx)
                tmr_pkg::IDX_CLOCK_EN:
                    s_d.rdata = {28'h0, s_q.psel, s_q.enable};
                tmr_pkg::IDX_WAVE:
                    s_d.rdata = {25'h0, s_q.cmp_en, s_q.auto_lock,
                                 s_q.mode};
                tmr_pkg::IDX_FORCED:
                    s_d.rdata = {29'h0, s_q.wo};
                tmr_pkg::IDX_SPLIT:
                    s_d.rdata = {31'h0, s_q.split};
                tmr_pkg::IDX_E_CLR,
                tmr_pkg::IDX_E_SET:
                    s_d.rdata = {30'h0, s_q.hold, s_q.dir};
                tmr_pkg::IDX_PERIOD:
                    s_d.rdata = {16'h0, s_q.period};
                tmr_pkg::IDX_CMP_BUF0:
                    s_d.rdata = {16'h0, s_q.cmp_buf[0]};
                tmr_pkg::IDX_CMP_BUF0 + 6'h01:
                    s_d.rdata = {16'h0, s_q.cmp_buf[1]};
                tmr_pkg::IDX_CMP_BUF0 + 6'h02:
                    s_d.rdata = {16'h0, s_q.cmp_buf[2]};
                tmr_pkg::IDX_COUNT:
                    s_d.rdata = {16'h0, s_q.count};
                tmr_pkg::IDX_STATUS:
                    s_d.rdata = {28'h0, s_q.bv, s_q.hold};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= STATE_RST;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // a stopped timer may still show forced levels when the pin is enabled
    assign waveform_oe_o = s_q.cmp_en &
        {3{(s_q.mode != tmr_pkg::WG_NORMAL) | ~s_q.enable}};
    assign waveform_out_o   = s_q.wo;
    assign clb_out_o        = s_q.wo;
    assign wb_dat_o         = s_q.rdata;
    assign overflow_event_o = s_q.ovf;
    assign update_event_o   = s_q.upd;
    assign split_enable_o   = s_q.split;
endmodule

/* design/tmr_wb_slave.sv */
// classic wishbone handshake for the timer register file
`timescale 1ns/1ns
module tmr_wb_slave (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic       we_i,
    input  wire logic [7:0] adr_i,
    input  wire logic [3:0] sel_i,
    output logic            ack_o,
    output logic            req_o,
    output logic            wr_o,
    output logic [5:0]      idx_o
);
    typedef struct packed {
        logic ack;
    } tmr_wb_type;

    tmr_wb_type s_q;
    tmr_wb_type s_d;

    // request seen in its first cycle; read data is captured there
    assign req_o = cyc_i & stb_i & ~s_q.ack;
    // writes land on the edge where the master samples ack
    assign wr_o  = cyc_i & stb_i & s_q.ack & we_i & sel_i[0];
    assign idx_o = adr_i[7:2];
    assign ack_o = s_q.ack;

    always_comb begin
        s_d     = s_q;
        s_d.ack = cyc_i & stb_i & ~s_q.ack;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end
endmodule

/* verification/tb_tmr_timer16.sv */
// self-checking bench for the 16-bit timer control block
`timescale 1ns/1ns
module tb_tmr_timer16;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dw = 32'h0;
    logic [31:0] rd;
    logic [31:0] q;
    logic        ack;
    logic [2:0]  wo;
    logic [2:0]  oe;
    logic [2:0]  clb;
    logic        ovf;
    logic        spl;
    int          bad_count = 0;
    int          checks = 0;
    always #20 clk_i = ~clk_i;
    tmr_timer16 dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(rd), .wb_ack_o(ack),
        .waveform_out_o(wo), .waveform_oe_o(oe), .clb_out_o(clb),
        .overflow_event_o(ovf), .update_event_o(), .split_enable_o(spl));
    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic [5:0] i, input logic w,
                      input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        dw <= {16'h0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        q = rd;
        chk("bus ack", {31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] i, input logic [15:0] d);
        wb(i, 1'b1, d);
    endtask
    task automatic rdc(input logic [5:0] i, input logic [31:0] e);
        wb(i, 1'b0, 16'h0000);
        chk($sformatf("reg %h", i), q, e);
    endtask
    // counts edges between two overflow pulses
    task automatic gap(input int e);
        int n;
        n = 0;
        while (ovf !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        n = 1;
        while (ovf !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        chk("overflow gap", n, e);
    endtask
    task automatic run(input logic [2:0] m, input logic [2:0] s, int e);
        wr(6'h00, 16'h0000);
        wr(6'h05, 16'h0008);
        wr(6'h01, {13'h0, m});
        wr(6'h00, {12'h000, s, 1'b1});
        gap(e);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 6; i++) rdc(i[5:0], 32'h0);
        rdc(6'h08, 32'hffff);
        rdc(6'h0d, 32'h0);
        wr(6'h06, 16'h00ff);
        rdc(6'h06, 32'h0);
        wr(6'h03, 16'h0001);
        rdc(6'h03, 32'h1);
        chk("split out", {31'h0, spl}, 32'h1);
        wr(6'h03, 16'h0000);
    endtask
    task automatic t_ctrl_e;
        wr(6'h05, 16'h0003);
        rdc(6'h04, 32'h3);
        wr(6'h04, 16'h0001);
        rdc(6'h05, 32'h2);
        wr(6'h05, 16'h0000);
        rdc(6'h04, 32'h2);
        wr(6'h04, 16'h0002);
        wr(6'h05, 16'h0004);
        rdc(6'h05, 32'h0);
    endtask
    task automatic t_rates;
        logic [2:0] md [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
        int gp [6] = '{4, 6, 4, 6, 3, 6};
        int dv [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
        logic [31:0] c;
        wr(6'h08, 16'h0003);
        wr(6'h09, 16'h0005);
        wr(6'h05, 16'h0004);
        for (int i = 0; i < 6; i++) run(md[i], 3'h0, gp[i]);
        for (int s = 0; s < 8; s++) run(3'h0, s[2:0], 4 * dv[s]);
        wr(6'h00, 16'h0000);
        wb(6'h0c, 1'b0, 16'h0000);
        c = q;
        repeat (10) @(posedge clk_i);
        rdc(6'h0c, c);
    endtask
    task automatic t_dir;
        wr(6'h05, 16'h0008);
        rdc(6'h04, 32'h0);
        wr(6'h05, 16'h0001);
        wr(6'h00, 16'h000f);
        // first tick after 1024 cycles; the next one is far away
        repeat (1100) @(posedge clk_i);
        rdc(6'h0c, 32'h3);
        wr(6'h00, 16'h0000);
        wr(6'h04, 16'h0001);
    endtask
    task automatic t_update;
        wr(6'h01, 16'h0000);
        wr(6'h05, 16'h0002);
        wr(6'h09, 16'h0007);
        rdc(6'h0d, 32'h3);
        wr(6'h05, 16'h0004);
        rdc(6'h0d, 32'h1);
        wr(6'h09, 16'h0007);
        wr(6'h00, 16'h0001);
        repeat (12) @(posedge clk_i);
        rdc(6'h0d, 32'h3);
        wr(6'h04, 16'h0002);
        repeat (8) @(posedge clk_i);
        rdc(6'h0d, 32'h0);
        wr(6'h00, 16'h0000);
    endtask
    task automatic t_autolock;
        wr(6'h01, 16'h0038);
        rdc(6'h0d, 32'h1);
        wr(6'h09, 16'h0007);
        rdc(6'h0d, 32'h3);
        wr(6'h0a, 16'h0007);
        rdc(6'h0d, 32'h6);
        wr(6'h00, 16'h0001);
        repeat (8) @(posedge clk_i);
        rdc(6'h0d, 32'h1);
        wr(6'h00, 16'h0000);
        wr(6'h01, 16'h0000);
        wr(6'h04, 16'h0002);
    endtask
    task automatic t_hard;
        wr(6'h01, 16'h0041);
        wr(6'h00, 16'h0001);
        wr(6'h05, 16'h000c);
        rdc(6'h01, 32'h41);
        wr(6'h00, 16'h0000);
        wr(6'h05, 16'h000c);
        rdc(6'h01, 32'h0);
        rdc(6'h08, 32'hffff);
    endtask
    task automatic t_forced;
        wr(6'h01, 16'h0070);
        wr(6'h02, 16'h0005);
        rdc(6'h02, 32'h5);
        chk("wave out", {29'h0, wo}, 32'h5);
        chk("logic out", {29'h0, clb}, 32'h5);
        chk("pin enable", {29'h0, oe}, 32'h7);
        wr(6'h00, 16'h0001);
        wr(6'h02, 16'h0002);
        rdc(6'h02, 32'h5);
        chk("pin enable", {29'h0, oe}, 32'h0);
        wr(6'h01, 16'h0071);
        chk("pin enable", {29'h0, oe}, 32'h7);
        wr(6'h00, 16'h0000);
    endtask
    // ------------------------------------------------------------
    // sequence and verdict
    // ------------------------------------------------------------
    task automatic give_verdict;
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ctrl_e();
        t_rates();
        t_dir();
        t_update();
        t_autolock();
        t_hard();
        t_forced();
        give_verdict();
    end
    // whole run needs about 12600 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
endmodule

/* verification/tmr_timer16_props.sv */
// assertion checker for the 16-bit timer control block
`timescale 1ns/1ns
module tmr_timer16_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [2:0]  waveform_out_o,
    input wire logic [2:0]  waveform_oe_o,
    input wire logic [2:0]  clb_out_o,
    input wire logic        overflow_event_o,
    input wire logic        update_event_o,
    input wire logic        split_enable_o
);
    // ------------------------------------------------------------
    // shadow of the control bits, taken from bus writes
    // ------------------------------------------------------------
    logic [7:0] wave_q;
    logic       en_q;
    logic       split_q;
    logic       wr_hit;
    logic       hard;
    logic [5:0] idx;
    assign idx = wb_adr_i[7:2];
    assign wr_hit = wb_ack_o && wb_we_i && wb_sel_i[0];
    // hard reset only counts while the timer is stopped
    assign hard = wr_hit && idx inside {6'h04, 6'h05}
                  && wb_dat_i[3:2] == 2'b11 && !en_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || hard) begin
            wave_q <= 8'h00;
            en_q <= 1'b0;
            split_q <= 1'b0;
        end else if (wr_hit) begin
            if (idx == 6'h00) en_q <= wb_dat_i[0];
            if (idx == 6'h01) wave_q <= wb_dat_i[7:0];
            if (idx == 6'h03) split_q <= wb_dat_i[0];
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack wider than one cycle");
    a_ack_answer: assert property
        (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property
        ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_cmd_reads_zero: assert property
        (wb_ack_o && !wb_we_i && wb_adr_i[7:3] == 5'h02
         |-> wb_dat_o[31:2] == 30'h0)
        else $error("control e read shows more than hold and dir");
    a_unmapped_zero: assert property
        (wb_ack_o && !wb_we_i && (idx inside {6'h06, 6'h07} || idx > 6'h0d)
         |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pin_enable: assert property (
        waveform_oe_o == (wave_q[6:4] & {3{wave_q[2:0] != 3'h0 || !en_q}}))
        else $error("pin enable wrong");
    a_clb_bypass: assert property (clb_out_o == waveform_out_o)
        else $error("logic block output differs from waveform");
    a_idle_no_ovf: assert property (
        (!en_q || split_q) && !$past(en_q && !split_q) |-> !overflow_event_o)
        else $error("overflow while stopped");
    a_split_level: assert property (
        $changed(split_q) |-> ##[0:1] split_enable_o == split_q)
        else $error("split output does not follow register");
    a_cmd_update: assert property (
        wr_hit && idx inside {6'h04, 6'h05} && wb_dat_i[3:2] == 2'b01
        |=> update_event_o)
        else $error("forced update gave no update pulse");
endmodule

bind tmr_timer16 tmr_timer16_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .waveform_out_o(waveform_out_o), .waveform_oe_o(waveform_oe_o),
    .clb_out_o(clb_out_o), .overflow_event_o(overflow_event_o),
    .update_event_o(update_event_o), .split_enable_o(split_enable_o));
